// >>> common/dpms_pkg.sv
// package for the dram page-mode sequencer: register map, field layout, codes, timing
// assumes a 100 MHz pclk and a 32-bit apb master
package dpms_pkg;

   // apb register byte offsets
   localparam logic [11:0] DPMS_OFF_CONFIG = 12'h000;
   localparam logic [11:0] DPMS_OFF_TIMING = 12'h004;
   localparam logic [11:0] DPMS_OFF_STATUS = 12'h008;

   // config register fields (system_module_config_reg)
   localparam int DPMS_CFG_W        = 9;
   localparam int DPMS_CFG_MODE0    = 0;   // [1:0] bank 0 page mode
   localparam int DPMS_CFG_MODE1    = 2;   // [3:2] bank 1 page mode
   localparam int DPMS_CFG_PORT0    = 4;   // [5:4] bank 0 port width
   localparam int DPMS_CFG_PORT1    = 6;   // [7:6] bank 1 port width
   localparam int DPMS_CFG_LOCK     = 8;   // bus_lock_bit
   localparam logic [DPMS_CFG_W-1:0] DPMS_CFG_RESET = 9'h000;

   // dram_timing_reg: extra wait clocks before each acknowledge
   localparam int DPMS_TIM_W = 2;
   localparam logic [DPMS_TIM_W-1:0] DPMS_TIM_RESET = 2'h0;

   // page modes
   localparam logic [1:0] DPMS_MODE_NORMAL = 2'h0;
   localparam logic [1:0] DPMS_MODE_FAST   = 2'h1;
   localparam logic [1:0] DPMS_MODE_BURST  = 2'h2;

   // port width codes
   localparam logic [1:0] DPMS_PORT_32 = 2'h0;
   localparam logic [1:0] DPMS_PORT_8  = 2'h1;
   localparam logic [1:0] DPMS_PORT_16 = 2'h2;

   // operand_width_code values
   localparam logic [1:0] DPMS_SZ_LONG = 2'h0;
   localparam logic [1:0] DPMS_SZ_BYTE = 2'h1;
   localparam logic [1:0] DPMS_SZ_WORD = 2'h2;
   localparam logic [1:0] DPMS_SZ_LINE = 2'h3;

   // address multiplexing
   localparam int DPMS_ROW_LSB   = 9;
   localparam int DPMS_MUX_W     = 19;
   localparam int DPMS_BANK_BIT  = 27;

   // ras precharge: rising edges between ras negation and the next start
   localparam int DPMS_GAP_EDGES = 2;
   localparam logic [1:0] DPMS_GAP_LOAD = 2'(DPMS_GAP_EDGES - 1);

   typedef enum logic [5:0] {
      DPMS_IDLE  = 6'h01,
      DPMS_PRECH = 6'h02,
      DPMS_ROW   = 6'h04,
      DPMS_COL   = 6'h08,
      DPMS_WAIT  = 6'h10,
      DPMS_ACK   = 6'h20
   } dpms_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        ext_master;
      logic [1:0]  size;
      logic [27:0] addr;
      logic [31:0] wdata;
   } dpms_req_t;

   typedef struct packed {
      logic [DPMS_MUX_W-1:0] mux_addr;
      logic                  transfer_start_n;
      logic                  memory_write_low;
      logic [1:0]            operand_width_code;
      logic [31:0]           dq_o;
      logic                  dq_oe;
      logic                  bus_oe;
   } dpms_pins_t;

endpackage : dpms_pkg

// >>> logic/dpms_sequencer.sv
// dram page-mode sequencer: fast page and burst page ras/cas sequencing, apb registers
// assumes core requests on pclk, dram data and bus grant arriving from pins
//
// Contract
// - external master in fast mode uses burst mode
// - first edge: row address (column address on a fast-mode page hit), start strobe, ras
// - second edge: strobe off, column address, cas
// - third edge: acknowledge, completes next edge
// - fast mode end: drop ack, cas; hold ras
// - idle grant loss unlocked: release bus, close ras
// - burst mode pages only operand-wider-than-port bursts
// - burst mode closes page after burst
// - burst mode non-burst runs as normal mode
// - reads and writes differ only in driver
// - burst three then two clocks, timing adds waits
// - non-burst in burst mode takes three clocks
// - width code in first clock, write data second
// - write-low indicator driven from first clock
// - between beats drop cas, next column, data
// - last beat drops ack, cas and, outside fast mode, ras; release data
// - two edges after ras close before restart; a fast-mode page miss restarts after one edge
// - read data captured edge after acknowledge
// - locked bus keeps ras and bus driven
`timescale 1ns/1ps
module dpms_sequencer
   import dpms_pkg::*;
(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // core / external master request side
   input  wire dpms_req_t   req,
   output logic             req_taken,
   output logic             xfer_ack,
   output logic             done,
   output logic      [31:0] rdata,
   // dram and bus pins
   output dpms_pins_t       pins,
   output logic      [1:0]  ras_n,
   output logic      [3:0]  cas_n,
   input  wire logic [31:0] dq_i,
   input  wire logic        bus_grant_input_n,
   output logic             bus_driven_flag_n
);

   typedef struct packed {
      dpms_state_t           fsm;
      logic [DPMS_CFG_W-1:0] cfg;
      logic [DPMS_TIM_W-1:0] tim;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic                  gnt_meta;
      logic                  gnt;
      logic                  owned;
      logic                  locked;
      logic [1:0]            page_open;
      logic [DPMS_MUX_W-1:0] open_row0;
      logic [DPMS_MUX_W-1:0] open_row1;
      logic                  bank;
      logic                  write;
      logic                  keep_open;
      logic [1:0]            port;
      logic [DPMS_MUX_W-1:0] row;
      logic [8:0]            col;
      logic [4:0]            beats_left;
      logic [DPMS_TIM_W-1:0] wait_cnt;
      logic [1:0]            gap;
      logic [31:0]           sh;
      logic [31:0]           rdata;
      logic                  req_taken;
      logic                  ack;
      logic                  done;
      logic [1:0]            ras_first;
      logic [1:0]            ras_second;
      logic                  cas_first;
      logic                  cas_second;
      dpms_pins_t            pins;
   } dpms_core_t;

   dpms_core_t s_reg;
   dpms_core_t s_next;

   // decoded request attributes
   logic                  req_bank;
   logic [1:0]            req_mode;
   logic [1:0]            eff_mode;
   logic [1:0]            req_port;
   logic [2:0]            op_lg;
   logic [2:0]            port_lg;
   logic                  req_burst;
   logic [4:0]            req_beats;
   logic [DPMS_MUX_W-1:0] req_row;
   logic                  req_hit;
   logic                  release_now;
   logic [3:0]            lane_mask;
   logic [7:0]            port_bytes;

   always_comb begin
      req_bank  = req.addr[DPMS_BANK_BIT];
      req_mode  = req_bank ? s_reg.cfg[DPMS_CFG_MODE1 +: 2] : s_reg.cfg[DPMS_CFG_MODE0 +: 2];
      req_port  = req_bank ? s_reg.cfg[DPMS_CFG_PORT1 +: 2] : s_reg.cfg[DPMS_CFG_PORT0 +: 2];
      // external masters never get fast page mode
      eff_mode  = (req_mode == DPMS_MODE_FAST && req.ext_master) ? DPMS_MODE_BURST
                                                                 : req_mode;
      unique case (req.size)
         DPMS_SZ_LONG: op_lg = 3'h2;
         DPMS_SZ_BYTE: op_lg = 3'h0;
         DPMS_SZ_WORD: op_lg = 3'h1;
         default:      op_lg = 3'h4;
      endcase
      unique case (req_port)
         DPMS_PORT_8:  port_lg = 3'h0;
         DPMS_PORT_16: port_lg = 3'h1;
         default:      port_lg = 3'h2;
      endcase
      req_burst = op_lg > port_lg;
      req_beats = req_burst ? 5'(5'h01 << (op_lg - port_lg)) : 5'h01;
      req_row   = req.addr[27:DPMS_ROW_LSB];
      req_hit   = eff_mode == DPMS_MODE_FAST && s_reg.page_open[req_bank]
                  && (req_bank ? s_reg.open_row1 : s_reg.open_row0) == req_row;
      release_now = s_reg.owned && !s_reg.gnt && !s_reg.locked
                    && s_reg.fsm == DPMS_IDLE;
      unique case (s_reg.port)
         DPMS_PORT_8:  lane_mask = 4'h1;
         DPMS_PORT_16: lane_mask = 4'h3;
         default:      lane_mask = 4'hF;
      endcase
      unique case (s_reg.port)
         DPMS_PORT_8:  port_bytes = 8'h01;
         DPMS_PORT_16: port_bytes = 8'h02;
         default:      port_bytes = 8'h04;
      endcase
   end

   always_comb begin
      s_next           = s_reg;
      s_next.req_taken = 1'b0;
      s_next.done      = 1'b0;
      s_next.pready    = 1'b0;
      s_next.pslverr   = 1'b0;

      // apb: one wait state, registered answer
      if (psel && penable && !s_reg.pready) begin
         s_next.pready = 1'b1;
         s_next.prdata = 32'h0000_0000;
         unique case (paddr)
            DPMS_OFF_CONFIG: begin
               if (pwrite) s_next.cfg = pwdata[DPMS_CFG_W-1:0];
               else s_next.prdata = {23'h000000, s_reg.cfg};
            end
            DPMS_OFF_TIMING: begin
               if (pwrite) s_next.tim = pwdata[DPMS_TIM_W-1:0];
               else s_next.prdata = {30'h00000000, s_reg.tim};
            end
            DPMS_OFF_STATUS: begin
               if (!pwrite) s_next.prdata = {14'h0000, s_reg.page_open, s_reg.locked,
                                             s_reg.owned, 6'h00, 2'(s_reg.fsm == DPMS_IDLE),
                                             s_reg.fsm};
            end
            default: s_next.pslverr = 1'b1;
         endcase
      end

      // bus grant synchroniser and arbitration
      s_next.gnt_meta = !bus_grant_input_n;
      s_next.gnt      = s_reg.gnt_meta;
      s_next.locked   = s_reg.cfg[DPMS_CFG_LOCK] && (s_reg.gnt || s_reg.locked);
      if (release_now) begin
         s_next.owned       = 1'b0;
         s_next.pins.bus_oe = 1'b0;
         s_next.ras_first   = 2'b00;
         s_next.ras_second  = 2'b00;
         s_next.page_open   = 2'b00;
         s_next.gap         = DPMS_GAP_LOAD;
      end else if (!s_reg.owned && s_reg.gnt) begin
         s_next.owned       = 1'b1;
         s_next.pins.bus_oe = 1'b1;
      end

      unique case (s_reg.fsm)
         DPMS_IDLE: begin
            s_next.ras_first  = s_next.ras_second;
            s_next.cas_first  = 1'b0;
            s_next.cas_second = 1'b0;
            if (s_reg.gap != 2'h0) begin
               s_next.gap = s_reg.gap - 2'h1;
            end else if (req.valid && s_reg.owned && !release_now) begin
               s_next.req_taken  = 1'b1;
               s_next.bank       = req_bank;
               s_next.write      = req.write;
               s_next.port       = req_port;
               s_next.row        = req_row;
               s_next.col        = req.addr[8:0];
               s_next.beats_left = req_beats;
               s_next.sh         = req.wdata;
               s_next.rdata      = 32'h0000_0000;
               // fast mode keeps its page; burst and normal close after the transfer
               s_next.keep_open  = eff_mode == DPMS_MODE_FAST;
               s_next.pins.memory_write_low   = !req.write;
               s_next.pins.operand_width_code = req.size;
               if (s_reg.page_open[req_bank] && !req_hit) begin
                  s_next.fsm = DPMS_PRECH;
                  s_next.ras_first[req_bank]  = 1'b0;
                  s_next.ras_second[req_bank] = 1'b0;
                  s_next.page_open[req_bank]  = 1'b0;
               end else begin
                  s_next.fsm = DPMS_ROW;
                  s_next.pins.transfer_start_n = 1'b0;
                  s_next.pins.mux_addr = req_hit ? {10'h000, req.addr[8:0]} : req_row;
                  s_next.ras_second[req_bank] = 1'b1;
                  s_next.page_open[req_bank]  = 1'b1;
                  if (req_bank) s_next.open_row1 = req_row;
                  else s_next.open_row0 = req_row;
               end
            end
         end
         DPMS_PRECH: begin
            s_next.fsm = DPMS_ROW;
            s_next.pins.transfer_start_n = 1'b0;
            s_next.pins.mux_addr = s_reg.row;
            s_next.ras_second[s_reg.bank] = 1'b1;
            s_next.page_open[s_reg.bank]  = 1'b1;
            if (s_reg.bank) s_next.open_row1 = s_reg.row;
            else s_next.open_row0 = s_reg.row;
         end
         DPMS_ROW: begin
            s_next.fsm = DPMS_COL;
            s_next.pins.transfer_start_n = 1'b1;
            s_next.pins.mux_addr  = {10'h000, s_reg.col};
            s_next.ras_first      = s_reg.ras_second;
            s_next.cas_second     = 1'b1;
            s_next.pins.dq_oe     = s_reg.write;
            s_next.pins.dq_o      = s_reg.sh;
         end
         DPMS_COL, DPMS_WAIT: begin
            s_next.cas_first = 1'b1;
            // one wait cycle per timing count before the acknowledge
            if (s_reg.fsm == DPMS_COL && s_reg.tim != 2'h0) begin
               s_next.fsm      = DPMS_WAIT;
               s_next.wait_cnt = s_reg.tim - 2'h1;
            end else if (s_reg.fsm == DPMS_WAIT && s_reg.wait_cnt != 2'h0) begin
               s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
            end else begin
               s_next.fsm = DPMS_ACK;
               s_next.ack = 1'b1;
            end
         end
         DPMS_ACK: begin
            s_next.ack = 1'b0;
            if (!s_reg.write) begin
               unique case (s_reg.port)
                  DPMS_PORT_8:  s_next.rdata = {s_reg.rdata[23:0], dq_i[31:24]};
                  DPMS_PORT_16: s_next.rdata = {s_reg.rdata[15:0], dq_i[31:16]};
                  default:      s_next.rdata = dq_i;
               endcase
            end
            s_next.cas_first = 1'b0;
            if (s_reg.beats_left > 5'h01) begin
               s_next.fsm        = DPMS_COL;
               s_next.beats_left = s_reg.beats_left - 5'h01;
               s_next.cas_second = 1'b1;
               s_next.col        = s_reg.col + {1'b0, port_bytes};
               s_next.pins.mux_addr = {10'h000, s_next.col};
               unique case (s_reg.port)
                  DPMS_PORT_8:  s_next.sh = {s_reg.sh[23:0], s_reg.sh[31:24]};
                  DPMS_PORT_16: s_next.sh = {s_reg.sh[15:0], s_reg.sh[31:16]};
                  default:      s_next.sh = s_reg.sh;
               endcase
               s_next.pins.dq_o = s_next.sh;
            end else begin
               s_next.fsm        = DPMS_IDLE;
               s_next.done       = 1'b1;
               s_next.cas_second = 1'b0;
               s_next.pins.dq_oe = 1'b0;
               if (!s_reg.keep_open) begin
                  s_next.ras_first[s_reg.bank]  = 1'b0;
                  s_next.ras_second[s_reg.bank] = 1'b0;
                  s_next.page_open[s_reg.bank]  = 1'b0;
                  s_next.gap = DPMS_GAP_LOAD;
               end  // fast mode leaves ras set here
            end
         end
         default: s_next.fsm = DPMS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg                         <= '0;
         s_reg.fsm                     <= DPMS_IDLE;
         s_reg.cfg                     <= DPMS_CFG_RESET;
         s_reg.tim                     <= DPMS_TIM_RESET;
         s_reg.pins.transfer_start_n   <= 1'b1;
         s_reg.pins.memory_write_low   <= 1'b1;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ras/cas pins change on both edges: a posedge and a negedge flop per pin,
   // xored, so the pin takes the first-half value at the rise and the
   // second-half value at the fall
   logic [5:0] rise_tog;
   logic [5:0] fall_tog;
   logic [5:0] first_next;
   logic [5:0] second_now;

   function automatic logic [3:0] lane_mask_next(input logic [1:0] p);
      lane_mask_next = (p == DPMS_PORT_8) ? 4'h1 : (p == DPMS_PORT_16) ? 4'h3 : 4'hF;
   endfunction : lane_mask_next

   assign first_next = {s_next.ras_first,
                        s_next.cas_first ? lane_mask_next(s_next.port) : 4'h0};
   assign second_now = {s_reg.ras_second, s_reg.cas_second ? lane_mask : 4'h0};

   for (genvar i = 0; i < 6; i++) begin : g_dual_edge
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) rise_tog[i] <= 1'b0;
         else if (ce) rise_tog[i] <= first_next[i] ^ fall_tog[i];
      end
      always_ff @(negedge pclk or negedge presetn) begin
         if (!presetn) fall_tog[i] <= 1'b0;
         else if (ce) fall_tog[i] <= second_now[i] ^ rise_tog[i];
      end
   end

   assign ras_n             = ~(rise_tog[5:4] ^ fall_tog[5:4]);
   assign cas_n             = ~(rise_tog[3:0] ^ fall_tog[3:0]);
   assign pins              = s_reg.pins;
   assign prdata            = s_reg.prdata;
   assign pready            = s_reg.pready;
   assign pslverr           = s_reg.pslverr;
   assign req_taken         = s_reg.req_taken;
   assign xfer_ack          = s_reg.ack;
   assign done              = s_reg.done;
   assign rdata             = s_reg.rdata;
   assign bus_driven_flag_n = !s_reg.owned;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_row_start_strobe: assert property (
      ce && s_reg.fsm == DPMS_ROW |-> !s_reg.pins.transfer_start_n
                                      && s_reg.ras_second[s_reg.bank])
      else $error("row cycle without start strobe or ras");
   a_col_switch: assert property (
      ce && s_reg.fsm == DPMS_ROW |=> s_reg.pins.transfer_start_n && s_reg.cas_second
                                      && s_reg.pins.mux_addr == {10'h000, s_reg.col})
      else $error("column phase not entered after row");
   a_ack_one_cycle: assert property (
      ce && s_reg.ack ##1 ce |-> !s_reg.ack)
      else $error("acknowledge longer than one cycle");
   a_fast_hold_ras: assert property (
      ce && s_reg.fsm == DPMS_ACK && s_reg.beats_left == 5'h01 && s_reg.keep_open
      |=> s_reg.ras_first[s_reg.bank] && !s_reg.cas_first && !s_reg.ack)
      else $error("fast page end did not hold ras");
   a_idle_release: assert property (
      ce && release_now |=> !s_reg.owned && !s_reg.pins.bus_oe && s_reg.ras_second == 2'b00)
      else $error("idle grant loss did not release bus");
   a_burst_close: assert property (
      ce && s_reg.fsm == DPMS_ACK && s_reg.beats_left == 5'h01 && !s_reg.keep_open
      |=> !s_reg.ras_first[s_reg.bank] && !s_reg.page_open[s_reg.bank] && !s_reg.pins.dq_oe)
      else $error("page not closed after burst");
   a_three_clock: assert property (
      ce && s_reg.fsm == DPMS_ROW && s_reg.tim == 2'h0 ##1 ce
      |-> s_reg.fsm == DPMS_COL ##1 s_reg.fsm == DPMS_ACK)
      else $error("fastest transfer not three clocks");
   a_gap_hold: assert property (
      s_reg.gap != 2'h0 |-> s_next.fsm != DPMS_ROW)
      else $error("transfer started inside ras precharge");
   a_write_low: assert property (
      s_reg.fsm == DPMS_ROW |-> s_reg.pins.memory_write_low == !s_reg.write)
      else $error("write indicator wrong in first clock");
   a_lock_keep: assert property (
      ce && s_reg.locked && s_reg.owned |=> s_reg.owned)
      else $error("locked bus lost mastership");

endmodule : dpms_sequencer

// >>> dv/dpms_dram_model.sv
// dram bank model: drives read data while any cas is low on a read
// assumes active-low cas from the sequencer and no pull on the data lines
`timescale 1ns/1ps
module dpms_dram_model
   import dpms_pkg::*;
#(
   parameter logic [31:0] DATA = 32'hC35A_96E1
)(
   // strobes
   input  wire dpms_pins_t  pins,
   input  wire logic [3:0]  cas_n,
   // data
   output logic      [31:0] dq_i
);
   // released lines show the inverse, never the data just read
   assign dq_i = (cas_n != 4'hF && pins.memory_write_low) ? DATA : ~DATA;
endmodule : dpms_dram_model

// >>> dv/test_dram_page_mode_sequencer.sv
// testbench for dpms_sequencer: apb set-up, transfer timing, grant loss and lock
// assumes dpms_dram_model on the data lines and a grant pin driven here
`timescale 1ns/1ps
module test_dram_page_mode_sequencer;
   import dpms_pkg::*;
   localparam logic [31:0] DATA = 32'hC35A_96E1;
   localparam logic [31:0] WD   = 32'hA1B2_C3D4;
   localparam logic [27:0] A0   = 28'h0ABC_DFE;
   localparam logic [27:0] A1   = 28'h8ABC_DFE;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        gnt_n   = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   dpms_req_t   req     = '0;
   logic [31:0] prdata, rdata, dq_i, rd;
   logic        pready, pslverr, req_taken, xfer_ack, done, bdf_n, perr;
   dpms_pins_t  pins;
   logic [1:0]  ras_n;
   logic [3:0]  cas_n;
   logic [15:0] beat [2];
   int          errors = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          last_done = -100;
   int          t_ack, gap, t_done, n_ack;

   always #5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   dpms_sequencer dpms_sequencer_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .req_taken(req_taken),
      .xfer_ack(xfer_ack), .done(done), .rdata(rdata), .pins(pins), .ras_n(ras_n),
      .cas_n(cas_n), .dq_i(dq_i), .bus_grant_input_n(gnt_n), .bus_driven_flag_n(bdf_n));
   dpms_dram_model #(.DATA(DATA)) dpms_dram_model_inst (.pins(pins), .cas_n(cas_n), .dq_i(dq_i));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   task automatic await(ref logic s, input logic v);
      for (int n = 0; n < 64 && s !== v; n++) begin
         @(posedge pclk);
         #1;
      end
      if (s !== v) begin
         errors++;
         wrap_up();
      end
   endtask : await

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      #1;
      await(pready, 1'b1);
      @(posedge pclk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // runs one request; cl is the ras level expected once it is done
   task automatic xfer(input logic w, x, input logic [1:0] sz, input logic [27:0] a,
                       input logic cl);
      int c0;
      @(posedge pclk);
      req <= '{1'b1, w, x, sz, a, WD};
      #1;
      await(req_taken, 1'b1);
      c0 = cyc;
      n_ack = 0;
      chk("gap", 32'(cyc - last_done >= 2), 1);
      chk("start", pins.transfer_start_n, 0);
      chk("row", pins.mux_addr, a[27:9]);
      chk("wlow", pins.memory_write_low, !w);
      chk("size", pins.operand_width_code, sz);
      @(posedge pclk);
      req.valid <= 1'b0;
      #1;
      chk("start off", pins.transfer_start_n, 1);
      chk("col", 32'(pins.mux_addr != a[27:9]), 1);
      chk("ras on", ras_n[a[27]], 0);
      chk("drive", pins.dq_oe, w);
      while (done !== 1'b1 && cyc - c0 < 40) begin
         @(posedge pclk);
         #1;
         if (n_ack == 1 && cyc - c0 == t_ack + 1 && done !== 1'b1) begin
            chk("cas gap", cas_n, 4'hF);
            chk("ras hold", ras_n[a[27]], 0);
         end
         if (xfer_ack === 1'b1) begin
            if (n_ack == 0) t_ack = cyc - c0;
            if (n_ack == 1) gap = cyc - c0 - t_ack;
            if (n_ack < 2) beat[n_ack] = pins.dq_o[31:16];
            n_ack++;
         end
      end
      await(done, 1'b1);
      t_done = cyc - c0;
      last_done = cyc;
      chk("ack off", xfer_ack, 0);
      chk("cas off", cas_n, 4'hF);
      chk("ras end", ras_n[a[27]], cl);
      chk("release", pins.dq_oe, 0);
   endtask : xfer

   task automatic s_regs();
      apb(1'b0, DPMS_OFF_CONFIG, 32'h0);
      chk("cfg reset", rd, 32'(DPMS_CFG_RESET));
      apb(1'b0, DPMS_OFF_STATUS, 32'h0);
      chk("status", rd, 32'h0000_4041);
      apb(1'b1, DPMS_OFF_CONFIG, 32'h0000_002A);
      apb(1'b0, DPMS_OFF_CONFIG, 32'h0);
      chk("cfg back", rd, 32'h0000_002A);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped", perr, 1);
   endtask : s_regs

   task automatic s_burst();
      for (int t = 2; t >= 0; t--) begin
         apb(1'b1, DPMS_OFF_TIMING, 32'(t));
         xfer(1'b1, 1'b0, DPMS_SZ_LONG, A0, 1'b1);
         chk("first beat", t_ack, 2 + t);
         chk("next beat", gap, 2 + t);
         chk("beat0 data", beat[0], WD[31:16]);
         chk("beat1 data", beat[1], WD[15:0]);
      end
      xfer(1'b0, 1'b0, DPMS_SZ_WORD, A0, 1'b1);
      chk("nonburst", t_done, 3);
      chk("word data", rdata, {16'h0000, DATA[31:16]});
      xfer(1'b0, 1'b0, DPMS_SZ_LINE, A1, 1'b1);
      chk("line beats", n_ack, 4);
      xfer(1'b0, 1'b0, DPMS_SZ_LONG, A1, 1'b1);
      chk("single beat", n_ack, 1);
      chk("read data", rdata, DATA);
   endtask : s_burst

   task automatic s_grant();
      apb(1'b1, DPMS_OFF_CONFIG, 32'h0000_0029);
      xfer(1'b1, 1'b1, DPMS_SZ_WORD, A0, 1'b1); // outside master closes the page
      xfer(1'b1, 1'b0, DPMS_SZ_WORD, A0, 1'b0); // core keeps the page open
      chk("other bank", ras_n[1], 1);
      repeat (2) @(posedge pclk);
      gnt_n <= 1'b1;
      #1;
      await(bdf_n, 1'b1);
      chk("ras closed", ras_n[0], 1);
      chk("bus off", pins.bus_oe, 0);
      @(posedge pclk);
      gnt_n <= 1'b0;
      #1;
      await(bdf_n, 1'b0);
      apb(1'b1, DPMS_OFF_CONFIG, 32'h0000_0129);
      xfer(1'b1, 1'b0, DPMS_SZ_WORD, A0, 1'b0);
      @(posedge pclk);
      gnt_n <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk("locked bd", bdf_n, 0);
      chk("locked ras", ras_n[0], 0);
      apb(1'b1, DPMS_OFF_CONFIG, 32'h0000_0029);
      #1;
      await(bdf_n, 1'b1);
      chk("unlocked ras", ras_n[0], 1);
   endtask : s_grant

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      await(bdf_n, 1'b0);
      s_regs();
      s_burst();
      s_grant();
      wrap_up();
   end
endmodule : test_dram_page_mode_sequencer
